// file: logic/timer_prescaler_and_trim_control.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
module timer_prescaler_and_trim_control
#(
  parameter int PORT_PINS = 32
)
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [2:0] first_timer_clksel_in,
  input wire logic [2:0] second_timer_clksel_in,
  input wire logic first_ext_count_pin_in,
  input wire logic second_ext_count_pin_in,
  input wire logic async_clock_select_in,
  input wire logic crystal_in_pin_in,
  input wire logic converter_enable_in,
  input wire logic [PORT_PINS-1:0] pullup_request_in,
  output logic first_timer_tick_out,
  output logic second_timer_tick_out,
  output timer_prescale_pkg::taps_t shared_taps_out,
  output logic third_timer_clock_source_out,
  output timer_prescale_pkg::taps_t third_taps_out,
  output logic crystal_pins_detach_out,
  output logic comparator_mux_select_out,
  output logic [PORT_PINS-1:0] pullup_enable_out,
  output logic [7:0] trim_value_out
);

  typedef struct packed {
    logic [timer_prescale_pkg::PRESC_W-1:0] shared_cnt;
    logic [timer_prescale_pkg::PRESC_W-1:0] async_cnt;
    timer_prescale_pkg::taps_t shared_taps;
    timer_prescale_pkg::taps_t async_taps;
    logic async_pending;
    logic pullup_disable_all;
    logic comparator_mux_enable;
    logic [7:0] trim_value;
    logic [7:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic first_rise;
  logic first_fall;
  logic second_rise;
  logic second_fall;
  logic xtal_rise;
  logic src_tick;
  logic sfc_wr;
  logic trim_wr;
  logic shared_rst_req;
  logic async_rst_req;
  logic [7:0] sfc_read;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  pin_edge_sync first_sync
  (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .pin_in(first_ext_count_pin_in),
    .level_out(),
    .rise_out(first_rise),
    .fall_out(first_fall)
  );

  pin_edge_sync second_sync
  (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .pin_in(second_ext_count_pin_in),
    .level_out(),
    .rise_out(second_rise),
    .fall_out(second_fall)
  );

  // The crystal is sampled, not used as a clock: it must run well below mclk
  pin_edge_sync xtal_sync
  (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .pin_in(crystal_in_pin_in),
    .level_out(),
    .rise_out(xtal_rise),
    .fall_out()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  assign sfc_wr = wr_in && (addr_in == timer_prescale_pkg::SFC_ADDR);
  assign trim_wr = wr_in && (addr_in == timer_prescale_pkg::TRIM_ADDR);
  assign shared_rst_req = sfc_wr && wdata_in[timer_prescale_pkg::SHARED_RST_BIT];
  assign async_rst_req = sfc_wr && wdata_in[timer_prescale_pkg::ASYNC_RST_BIT];
  assign src_tick = async_clock_select_in ? xtal_rise : 1'b1;

  always_comb
  begin
    sfc_read = {timer_prescale_pkg::SFC_RSVD_READ,
                st_r.comparator_mux_enable,
                st_r.pullup_disable_all,
                st_r.async_pending & async_clock_select_in,
                1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    st_nxt = st_r;
    // Shared prescaler counts every clock; a reset request wins over the count
    if (shared_rst_req)
    begin
      st_nxt.shared_cnt = '0;
      st_nxt.shared_taps = '0;
    end
    else
    begin
      st_nxt.shared_cnt = st_r.shared_cnt + 1'b1;
      st_nxt.shared_taps = timer_prescale_pkg::tap_pulses(st_r.shared_cnt);
    end
    // Third prescaler advances on its selected source
    st_nxt.async_taps = '0;
    if (async_rst_req && !async_clock_select_in)
    begin
      st_nxt.async_cnt = '0;
      st_nxt.async_pending = 1'b0;
    end
    else if (src_tick)
    begin
      if (st_r.async_pending)
      begin
        // Reset lands on the crystal tick, then the bit is released
        st_nxt.async_cnt = '0;
        st_nxt.async_pending = 1'b0;
      end
      else
      begin
        st_nxt.async_cnt = st_r.async_cnt + 1'b1;
        st_nxt.async_taps = timer_prescale_pkg::tap_pulses(st_r.async_cnt);
      end
    end
    // A new request in the completing cycle is kept, not lost
    if (async_rst_req && async_clock_select_in)
      st_nxt.async_pending = 1'b1;
    if (sfc_wr)
    begin
      st_nxt.pullup_disable_all = wdata_in[timer_prescale_pkg::PULLUP_DIS_BIT];
      st_nxt.comparator_mux_enable = wdata_in[timer_prescale_pkg::CMP_MUX_BIT];
    end
    if (trim_wr)
      st_nxt.trim_value = wdata_in;
    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (rd_in)
    begin
      case (addr_in)
        timer_prescale_pkg::SFC_ADDR: st_nxt.rdata = sfc_read;
        timer_prescale_pkg::TRIM_ADDR: st_nxt.rdata = st_r.trim_value;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= '0;
      st_r.pullup_disable_all <= timer_prescale_pkg::SFC_RESET[timer_prescale_pkg::PULLUP_DIS_BIT];
      st_r.comparator_mux_enable <= timer_prescale_pkg::SFC_RESET[timer_prescale_pkg::CMP_MUX_BIT];
      st_r.trim_value <= timer_prescale_pkg::TRIM_RESET;
    end
    else
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tap selection and outputs

  timer_clock_select first_sel
  (
    .clksel_in(first_timer_clksel_in),
    .taps_in(st_r.shared_taps),
    .ext_rise_in(first_rise),
    .ext_fall_in(first_fall),
    .tick_out(first_timer_tick_out)
  );

  timer_clock_select second_sel
  (
    .clksel_in(second_timer_clksel_in),
    .taps_in(st_r.shared_taps),
    .ext_rise_in(second_rise),
    .ext_fall_in(second_fall),
    .tick_out(second_timer_tick_out)
  );

  assign rdata_out = st_r.rdata;
  assign shared_taps_out = st_r.shared_taps;
  assign third_timer_clock_source_out = src_tick;
  assign third_taps_out = st_r.async_taps;
  assign crystal_pins_detach_out = async_clock_select_in;
  // Converter enabled means the mux is busy, so the dedicated pin is used
  assign comparator_mux_select_out = st_r.comparator_mux_enable & ~converter_enable_in;
  assign pullup_enable_out = st_r.pullup_disable_all ? '0 : pullup_request_in;
  assign trim_value_out = st_r.trim_value;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence async_req_s;
    async_rst_req && async_clock_select_in;
  endsequence

  sequence async_wait_s;
    st_r.async_pending && !xtal_rise && async_clock_select_in;
  endsequence

  sequence sfc_read_s;
    rd_in && (addr_in == timer_prescale_pkg::SFC_ADDR);
  endsequence

  shared_count_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    !shared_rst_req |=> st_r.shared_cnt == $past(st_r.shared_cnt) + 10'h001)
    else $error("shared prescaler did not advance");

  shared_reset_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    shared_rst_req ##1 !shared_rst_req |-> st_r.shared_cnt == 10'h000 ##1 st_r.shared_cnt == 10'h001)
    else $error("shared prescaler reset failed");

  zero_write_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    sfc_wr && !wdata_in[timer_prescale_pkg::SHARED_RST_BIT] && !wdata_in[timer_prescale_pkg::ASYNC_RST_BIT]
    && !st_r.async_pending
    |=> !st_r.async_pending && (st_r.shared_cnt != 10'h000 || $past(st_r.shared_cnt) == 10'h3ff))
    else $error("zero write disturbed a prescaler");

  shared_read_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    sfc_read_s |=> rdata_out[timer_prescale_pkg::SHARED_RST_BIT] == 1'b0
    && rdata_out[7:4] == timer_prescale_pkg::SFC_RSVD_READ)
    else $error("shared reset or reserved bits read nonzero");

  sync_read_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    sfc_read_s and !async_clock_select_in |=> rdata_out[timer_prescale_pkg::ASYNC_RST_BIT] == 1'b0)
    else $error("async reset bit read one in synchronous mode");

  async_hold_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    async_req_s ##1 async_wait_s |=> st_r.async_pending)
    else $error("async reset bit dropped before completion");

  async_done_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    st_r.async_pending && xtal_rise && async_clock_select_in && !async_rst_req
    |=> !st_r.async_pending && st_r.async_cnt == 10'h000)
    else $error("async reset not completed on crystal tick");

  sync_reset_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    async_rst_req && !async_clock_select_in |=> st_r.async_cnt == 10'h000 && !st_r.async_pending)
    else $error("third prescaler not reset");

  source_sel_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    !async_clock_select_in |-> third_timer_clock_source_out)
    else $error("third timer lost system clock source");

  tap1024_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    $past(st_r.shared_cnt) == 10'h3ff && !$past(shared_rst_req) |-> shared_taps_out.div1024 && shared_taps_out.div8)
    else $error("divide by 1024 tap missing");

  stop_sel_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    first_timer_clksel_in == timer_prescale_pkg::CS_STOP |-> !first_timer_tick_out)
    else $error("stopped timer received a tick");

  cmp_mux_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    $rose(st_r.comparator_mux_enable) && !converter_enable_in |-> comparator_mux_select_out)
    else $error("comparator mux not selected");

  pullup_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    sfc_wr && wdata_in[timer_prescale_pkg::PULLUP_DIS_BIT] |=> pullup_enable_out == '0)
    else $error("pull-up still enabled after disable");

  trim_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    trim_wr |=> trim_value_out == $past(wdata_in))
    else $error("trim value not applied");

  div1_tick_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    first_timer_clksel_in == timer_prescale_pkg::CS_DIV1 |-> first_timer_tick_out)
    else $error("undivided select lost a tick");

  async_read_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    sfc_read_s and (st_r.async_pending && async_clock_select_in) |=> rdata_out[timer_prescale_pkg::ASYNC_RST_BIT])
    else $error("pending async reset read as zero");

  pullup_pass_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    !st_r.pullup_disable_all |-> pullup_enable_out == pullup_request_in)
    else $error("pull-up requests not passed through");

  // Only the uninterrupted count is checked; a pending reset, or a new one in synchronous mode, takes the tick instead
  third_tap_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    src_tick && !async_rst_req && !st_r.async_pending && st_r.async_cnt == 10'h3ff
    |=> third_taps_out.div1024 && third_taps_out.div8)
    else $error("third prescaler tap missing");

endmodule

// file: logic/timer_prescale_pkg.sv
package timer_prescale_pkg;

  // Register map, byte addresses on the plain register port
  localparam logic [7:0] SFC_ADDR = 8'h30;
  localparam logic [7:0] TRIM_ADDR = 8'h31;
  localparam logic [7:0] SFC_RESET = 8'h00;
  localparam logic [7:0] TRIM_RESET = 8'h00;

  // special_function_control field positions
  localparam int SHARED_RST_BIT = 0;
  localparam int ASYNC_RST_BIT = 1;
  localparam int PULLUP_DIS_BIT = 2;
  localparam int CMP_MUX_BIT = 3;
  localparam logic [3:0] SFC_RSVD_READ = 4'h0;

  // Prescaler geometry
  localparam int PRESC_W = 10;
  localparam int DIV8_BITS = 3;
  localparam int DIV64_BITS = 6;
  localparam int DIV256_BITS = 8;
  localparam int DIV1024_BITS = 10;

  // Clock select codes of the first two timers
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  typedef struct packed {
    logic div1024;
    logic div256;
    logic div64;
    logic div8;
  } taps_t;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_state_t;

  // A tap fires in the cycle after its low counter bits are all ones
  function automatic taps_t tap_pulses(input logic [PRESC_W-1:0] cnt);
    taps_t t;
    t.div8 = &cnt[DIV8_BITS-1:0];
    t.div64 = &cnt[DIV64_BITS-1:0];
    t.div256 = &cnt[DIV256_BITS-1:0];
    t.div1024 = &cnt[DIV1024_BITS-1:0];
    return t;
  endfunction

endpackage

// file: logic/pin_edge_sync.sv
`timescale 1ns/1ps
module pin_edge_sync
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);

  timer_prescale_pkg::sync_state_t st_r;
  timer_prescale_pkg::sync_state_t st_nxt;

  always_comb
  begin
    st_nxt.meta = pin_in;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Edges are only seen if the pin holds each level a full clock period
  assign level_out = st_r.sync;
  assign rise_out = st_r.sync & ~st_r.prev;
  assign fall_out = ~st_r.sync & st_r.prev;

endmodule

// file: logic/timer_clock_select.sv
`timescale 1ns/1ps
module timer_clock_select
(
  input wire logic [2:0] clksel_in,
  input wire timer_prescale_pkg::taps_t taps_in,
  input wire logic ext_rise_in,
  input wire logic ext_fall_in,
  output logic tick_out
);

  always_comb
  begin
    case (clksel_in)
      timer_prescale_pkg::CS_STOP: tick_out = 1'b0;
      timer_prescale_pkg::CS_DIV1: tick_out = 1'b1;
      timer_prescale_pkg::CS_DIV8: tick_out = taps_in.div8;
      timer_prescale_pkg::CS_DIV64: tick_out = taps_in.div64;
      timer_prescale_pkg::CS_DIV256: tick_out = taps_in.div256;
      timer_prescale_pkg::CS_DIV1024: tick_out = taps_in.div1024;
      timer_prescale_pkg::CS_EXT_FALL: tick_out = ext_fall_in;
      timer_prescale_pkg::CS_EXT_RISE: tick_out = ext_rise_in;
      default: tick_out = 1'b0;
    endcase
  end

endmodule

// file: dv/timer_tick_counter.sv
`timescale 1ns/1ps
// Stand-in for a timer counter: advances once per enable pulse it is given
module timer_tick_counter
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  output logic [15:0] count_out
);
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      count_out <= 16'h0000;
    else if (tick_in)
      count_out <= count_out + 16'h0001;
  end
endmodule

// file: dv/timer_prescaler_and_trim_control_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module timer_prescaler_and_trim_control_bench;
  localparam logic [15:0] SEL_TICKS [8] = '{16'h0000, 16'h0041, 16'h0008, 16'h0001,
    16'h0000, 16'h0000, 16'h0003, 16'h0003};
  localparam logic [15:0] TAP_LEN [4] = '{16'h0008, 16'h0040, 16'h0100, 16'h0400};
  localparam logic [7:0] SFC = timer_prescale_pkg::SFC_ADDR;
  localparam logic [7:0] TRIM = timer_prescale_pkg::TRIM_ADDR;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic [2:0] clksel = 3'h0;
  logic ext_pin = 1'b0;
  logic async_sel = 1'b0;
  logic crystal = 1'b0;
  logic conv_en = 1'b0;
  logic [31:0] pull_req = 32'ha5c3_0f96;
  logic tick1, tick2, src3, detach, mux_sel;
  timer_prescale_pkg::taps_t shared_taps, third_taps;
  logic [31:0] pull_en;
  logic [7:0] trim;
  logic [15:0] cnt1, cnt2, cnt3;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;

  //////////////////////////////////////////////////////////////////////////////
  timer_prescaler_and_trim_control timer_prescaler_and_trim_control_i
  (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .first_timer_clksel_in(clksel), .second_timer_clksel_in(~clksel),
    .first_ext_count_pin_in(ext_pin), .second_ext_count_pin_in(ext_pin),
    .async_clock_select_in(async_sel), .crystal_in_pin_in(crystal),
    .converter_enable_in(conv_en), .pullup_request_in(pull_req),
    .first_timer_tick_out(tick1), .second_timer_tick_out(tick2),
    .shared_taps_out(shared_taps), .third_timer_clock_source_out(src3),
    .third_taps_out(third_taps), .crystal_pins_detach_out(detach),
    .comparator_mux_select_out(mux_sel), .pullup_enable_out(pull_en), .trim_value_out(trim)
  );
  timer_tick_counter timer_tick_counter_i
  (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .tick_in(tick1), .count_out(cnt1));
  timer_tick_counter second_counter_i
  (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .tick_in(tick2), .count_out(cnt2));
  timer_tick_counter third_counter_i
  (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .tick_in(src3), .count_out(cnt3));

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #20 mclk_in = ~mclk_in;
  end

  // Ceiling well above the roughly 2000 cycles the sequence needs
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  // Counts clock edges until the chosen tap pulses, from the current edge
  task automatic tap_gap(input logic third, input int k, output logic [15:0] n);
    n = 16'h0000;
    do
    begin
      @(posedge mclk_in);
      #1;
      n++;
    end while ((third ? third_taps[k] : shared_taps[k]) !== 1'b1 && n < 16'h0800);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] v;
    logic [15:0] n, a, b;
    repeat (10) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    rd(SFC, v);
    `CHK(v, timer_prescale_pkg::SFC_RESET)
    rd(TRIM, v);
    `CHK(v, timer_prescale_pkg::TRIM_RESET)
    wr(TRIM, 8'hff);
    rd(TRIM, v);
    `CHK(v, 8'hff)
    `CHK(trim, 8'hff)
    wr(8'h32, 8'h5a);
    rd(8'h32, v);
    `CHK(v, 8'h00)
    wr(TRIM, 8'h00);
    rd(TRIM, v);
    `CHK(trim, 8'h00)
    wr(SFC, 8'hfc);
    rd(SFC, v);
    `CHK(v, 8'h0c)
    `CHK(pull_en, 32'h0000_0000)
    `CHK(mux_sel, 1'b1)
    @(posedge mclk_in);
    conv_en <= 1'b1;
    @(posedge mclk_in);
    #1;
    `CHK(mux_sel, 1'b0)
    wr(SFC, 8'h00);
    rd(SFC, v);
    `CHK(pull_en, pull_req)
    wr(SFC, 8'h01);
    rd(SFC, v);
    `CHK(v, 8'h00)
    // Each tap measured from a fresh prescaler clear
    for (int k = 0; k < 4; k++)
    begin
      wr(SFC, 8'h01);
      tap_gap(1'b0, k, n);
      `CHK(n, TAP_LEN[k])
      @(posedge mclk_in);
      #1;
      `CHK(shared_taps[k], 1'b0)
    end
    // Every select code on both timers over one 65-cycle window
    for (int c = 0; c < 8; c++)
    begin
      @(posedge mclk_in);
      clksel <= 3'(c);
      wr(SFC, 8'h01);
      #1;
      a = cnt1;
      b = cnt2;
      fork
        repeat (65) @(posedge mclk_in);
        repeat (3)
        begin
          repeat (2) @(posedge mclk_in);
          ext_pin <= 1'b1;
          repeat (2) @(posedge mclk_in);
          ext_pin <= 1'b0;
        end
      join
      #1;
      `CHK(cnt1 - a, SEL_TICKS[c])
      `CHK(cnt2 - b, SEL_TICKS[7-c])
    end
    `CHK(src3, 1'b1)
    `CHK(detach, 1'b0)
    wr(SFC, 8'h02);
    tap_gap(1'b1, 0, n);
    `CHK(n, TAP_LEN[0])
    rd(SFC, v);
    `CHK(v, 8'h00)
    @(posedge mclk_in);
    async_sel <= 1'b1;
    @(posedge mclk_in);
    #1;
    `CHK(detach, 1'b1)
    a = cnt3;
    wr(SFC, 8'h02);
    rd(SFC, v);
    `CHK(v, 8'h02)
    wr(SFC, 8'h00);
    rd(SFC, v);
    `CHK(v, 8'h02)
    @(posedge mclk_in);
    crystal <= 1'b1;
    repeat (6) @(posedge mclk_in);
    crystal <= 1'b0;
    repeat (6) @(posedge mclk_in);
    rd(SFC, v);
    `CHK(v, 8'h00)
    `CHK(cnt3 - a, 16'h0001)
    summarize();
  end
endmodule
